// file: inc/boot_flash_pkg.sv
`default_nettype none
package boot_flash_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FUSE = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_APP_LOCK_LSB = 0;
    localparam int CTRL_BOOT_LOCK_LSB = 2;
    localparam int FUSE_BOOT_SIZE_LSB = 0;
    localparam int CMD_ERASE_BIT = 16;
    localparam int CMD_FROM_BOOT_BIT = 17;
    localparam int CMD_BUSY_CLR_BIT = 18;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_STALL_BIT = 1;
    localparam int STAT_ACTIVE_BIT = 2;
    localparam int STAT_REJECT_BIT = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] LOCK_RESET = 2'h3;
    localparam logic [1:0] BOOT_SIZE_RESET = 2'h0;

    // ------------------------------------------------------------
    // Lock pair codes (1 = unprogrammed)
    // ------------------------------------------------------------
    localparam logic [1:0] LOCK_NONE = 2'h3;
    localparam logic [1:0] LOCK_WRITE = 2'h2;
    localparam logic [1:0] LOCK_ALL = 2'h0;
    localparam logic [1:0] LOCK_READ = 2'h1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int PROG_TIME_US = 4;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PROG
    } prog_state_e;

endpackage : boot_flash_pkg
`default_nettype wire

// file: rtl/boot_flash_ctrl.sv
// Summary of operation
// - A self-write issued from the application section never starts programming.
// - A self-write from the boot section may erase or write any page, boot pages included.
// - The application/boot boundary is set by the boot size fuses.
// - Application protection follows the application lock bits alone.
// - Boot section protection follows the boot section lock bits.
// - Both lock pairs are set independently, so any mix of protection is possible.
// - Stall versus concurrent fetch is chosen by the target page address, not the boot boundary.
// - Programming a concurrent-read page keeps fetches from the halting section served.
// - Programming a halting-section page stalls the CPU for the whole operation.
// - The boot section always lies inside the halting section.
// - The busy flag reads one while the concurrent-read section is blocked.
// - The busy flag stays set after programming until software clears it.
// - Application lock codes: 11 free, 10 no self-write, 00 no self-write or boot reads, 01 no boot reads.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module boot_flash_ctrl #(
    parameter int ADDR_W = 16,
    parameter int PAGE_LSB = 8,
    parameter int HALT_BASE = 16'he000,
    parameter int PROG_CYCLES = boot_flash_pkg::PROG_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ADDR_W-1:0] fetch_addr,
    input wire logic fetch_from_app,
    output logic cpu_stall,
    output logic boot_read_block,
    output logic app_read_block,
    output logic flash_op_start,
    output logic flash_op_erase,
    output logic [ADDR_W-1:0] flash_op_addr
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [1:0] app_lock_q;
    logic [1:0] boot_lock_q;
    logic [1:0] boot_size_q;
    logic busy_q;
    logic reject_q;
    logic [15:0] cnt_q;
    boot_flash_pkg::prog_state_e state_q;

    logic setup_ph;
    logic wr_acc;
    logic addr_ok;
    logic cmd_clr;
    logic [ADDR_W-1:0] boot_base;
    logic [ADDR_W-1:0] cmd_addr;
    logic cmd_go;
    logic cmd_from_boot;
    logic cmd_erase;
    logic tgt_boot;
    logic tgt_rww;
    logic allowed;
    logic start;
    logic done;

    // ------------------------------------------------------------
    // Section decode
    // ------------------------------------------------------------
    always_comb begin
        unique case (boot_size_q)
            2'h0: boot_base = ADDR_W'(HALT_BASE);
            2'h1: boot_base = ADDR_W'(HALT_BASE + (1 << (ADDR_W - 4)));
            2'h2: boot_base = ADDR_W'(HALT_BASE + (3 << (ADDR_W - 5)));
            default: boot_base = ADDR_W'(HALT_BASE + (7 << (ADDR_W - 6)));
        endcase
    end

    assign setup_ph = psel && !penable;
    assign addr_ok = (paddr == boot_flash_pkg::ADDR_CTRL) || (paddr == boot_flash_pkg::ADDR_FUSE) ||
        (paddr == boot_flash_pkg::ADDR_CMD) || (paddr == boot_flash_pkg::ADDR_STAT);
    assign wr_acc = psel && penable && pready && pwrite && addr_ok;
    assign cmd_go = wr_acc && (paddr == boot_flash_pkg::ADDR_CMD);
    assign cmd_clr = pwdata[boot_flash_pkg::CMD_BUSY_CLR_BIT];
    assign cmd_addr = pwdata[ADDR_W-1:0];
    assign cmd_erase = pwdata[boot_flash_pkg::CMD_ERASE_BIT];
    assign cmd_from_boot = pwdata[boot_flash_pkg::CMD_FROM_BOOT_BIT];
    assign tgt_boot = cmd_addr >= boot_base;
    assign tgt_rww = cmd_addr < ADDR_W'(HALT_BASE);

    always_comb begin
        allowed = cmd_from_boot;
        if (tgt_boot) begin
            allowed = allowed && boot_lock_q[1:0] != boot_flash_pkg::LOCK_WRITE &&
                boot_lock_q != boot_flash_pkg::LOCK_ALL;
        end else begin
            allowed = allowed && app_lock_q != boot_flash_pkg::LOCK_WRITE &&
                app_lock_q != boot_flash_pkg::LOCK_ALL;
        end
    end

    // Clear-busy commands never start a page operation
    assign start = cmd_go && !cmd_clr && state_q == boot_flash_pkg::ST_IDLE && allowed;
    assign done = state_q == boot_flash_pkg::ST_PROG && cnt_q == 16'h0001;

    // ------------------------------------------------------------
    // Lock and fuse registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            app_lock_q <= boot_flash_pkg::LOCK_RESET;
            boot_lock_q <= boot_flash_pkg::LOCK_RESET;
        end else if (wr_acc && paddr == boot_flash_pkg::ADDR_CTRL) begin
            app_lock_q <= pwdata[boot_flash_pkg::CTRL_APP_LOCK_LSB +: 2];
            boot_lock_q <= pwdata[boot_flash_pkg::CTRL_BOOT_LOCK_LSB +: 2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            boot_size_q <= boot_flash_pkg::BOOT_SIZE_RESET;
        end else if (wr_acc && paddr == boot_flash_pkg::ADDR_FUSE) begin
            boot_size_q <= pwdata[boot_flash_pkg::FUSE_BOOT_SIZE_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // Programming sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= boot_flash_pkg::ST_IDLE;
            cnt_q <= 16'h0000;
            cpu_stall <= 1'b0;
        end else begin
            unique case (state_q)
                boot_flash_pkg::ST_IDLE: begin
                    if (start) begin
                        state_q <= boot_flash_pkg::ST_PROG;
                        cnt_q <= 16'(PROG_CYCLES);
                        cpu_stall <= !tgt_rww;
                    end
                end
                boot_flash_pkg::ST_PROG: begin
                    cnt_q <= cnt_q - 16'h0001;
                    if (done) begin
                        state_q <= boot_flash_pkg::ST_IDLE;
                        cpu_stall <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flash_op_start <= 1'b0;
            flash_op_erase <= 1'b0;
            flash_op_addr <= '0;
        end else begin
            flash_op_start <= start;
            if (start) begin
                flash_op_erase <= cmd_erase;
                flash_op_addr <= {cmd_addr[ADDR_W-1:PAGE_LSB], PAGE_LSB'(0)};
            end
        end
    end

    // ------------------------------------------------------------
    // Busy flag: set wins over software clear
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else if (start && tgt_rww) begin
            busy_q <= 1'b1;
        end else if (cmd_go && cmd_clr && cmd_from_boot &&
            state_q == boot_flash_pkg::ST_IDLE) begin
            busy_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reject_q <= 1'b0;
        end else if (cmd_go && !cmd_clr) begin
            reject_q <= !start;
        end
    end

    // ------------------------------------------------------------
    // Read blocking toward the CPU
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            boot_read_block <= 1'b0;
            app_read_block <= 1'b0;
        end else begin
            boot_read_block <= fetch_from_app && fetch_addr >= boot_base &&
                !boot_lock_q[1];
            app_read_block <= !fetch_from_app && fetch_addr < boot_base &&
                !app_lock_q[1];
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph && !addr_ok;
            prdata <= 32'h0000_0000;
            if (setup_ph && !pwrite) begin
                unique case (paddr)
                    boot_flash_pkg::ADDR_CTRL: prdata <= {28'h0, boot_lock_q, app_lock_q};
                    boot_flash_pkg::ADDR_FUSE: prdata <= {30'h0, boot_size_q};
                    boot_flash_pkg::ADDR_STAT: prdata <= {28'h0, reject_q,
                        state_q == boot_flash_pkg::ST_PROG, cpu_stall, busy_q};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : boot_flash_ctrl

`default_nettype wire

// file: test/boot_flash_ctrl_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Port checks
// ------------------------------------------------------------
module boot_flash_ctrl_asserts #(
    parameter int ADDR_W = 16,
    parameter int PAGE_LSB = 8,
    parameter int HALT_BASE = 16'he000,
    parameter int PROG_CYCLES = boot_flash_pkg::PROG_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [ADDR_W-1:0] fetch_addr,
    input wire logic fetch_from_app,
    input wire logic cpu_stall,
    input wire logic boot_read_block,
    input wire logic app_read_block,
    input wire logic flash_op_start,
    input wire logic [ADDR_W-1:0] flash_op_addr
);
    logic cmd_go;
    logic [ADDR_W-1:0] tgt;
    logic [15:0] cnt_q;
    assign cmd_go = psel && penable && pready && pwrite && paddr == boot_flash_pkg::ADDR_CMD &&
        pwdata[boot_flash_pkg::CMD_FROM_BOOT_BIT] && !pwdata[boot_flash_pkg::CMD_BUSY_CLR_BIT];
    assign tgt = pwdata[ADDR_W-1:0] >> PAGE_LSB << PAGE_LSB;
    always_ff @(posedge core_clk) begin
        cnt_q <= (!rst_n || !cpu_stall) ? 16'h0 : cnt_q + 16'h1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_start_cause; flash_op_start |-> $past(cmd_go); endproperty
    a_start_cause: assert property (p_start_cause) else $error("start without boot command");
    property p_start_addr; flash_op_start |-> flash_op_addr == $past(tgt); endproperty
    a_start_addr: assert property (p_start_addr) else $error("wrong page address");
    property p_stall_pick; flash_op_start |-> cpu_stall == (flash_op_addr >= HALT_BASE); endproperty
    a_stall_pick: assert property (p_stall_pick) else $error("stall not chosen by target");
    property p_stall_len; $fell(cpu_stall) |-> cnt_q == PROG_CYCLES; endproperty
    a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
    property p_no_restart; cpu_stall && $past(cpu_stall) |-> !flash_op_start; endproperty
    a_no_restart: assert property (p_no_restart) else $error("start during operation");
    property p_answer; psel && !penable |=> pready ##1 !pready; endproperty
    a_answer: assert property (p_answer) else $error("bus answer timing wrong");
    property p_err; pready |-> pslverr == (paddr > 8'h0c || paddr[1:0] != 2'h0); endproperty
    a_err: assert property (p_err) else $error("error response wrong");
    property p_boot_blk; boot_read_block |-> $past(fetch_from_app) && $past(fetch_addr) >= HALT_BASE; endproperty
    a_boot_blk: assert property (p_boot_blk) else $error("boot read block wrong");
    property p_app_blk; app_read_block |-> !$past(fetch_from_app); endproperty
    a_app_blk: assert property (p_app_blk) else $error("app read block wrong");
    c_stall: cover property (flash_op_start && cpu_stall);
    c_rww: cover property (flash_op_start && !cpu_stall);
    c_err: cover property (pready && pslverr);
endmodule : boot_flash_ctrl_asserts
bind boot_flash_ctrl boot_flash_ctrl_asserts #(.ADDR_W(ADDR_W), .PAGE_LSB(PAGE_LSB), .HALT_BASE(HALT_BASE),
    .PROG_CYCLES(PROG_CYCLES)) u_chk (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .fetch_addr(fetch_addr), .fetch_from_app(fetch_from_app), .cpu_stall(cpu_stall),
    .boot_read_block(boot_read_block), .app_read_block(app_read_block),
    .flash_op_start(flash_op_start), .flash_op_addr(flash_op_addr));
`default_nettype wire

// file: test/cpu_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Fetching core
// ------------------------------------------------------------
module cpu_core_model #(
    parameter int HALT_BASE = 16'he000
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cpu_stall,
    input wire logic rww_busy,
    input wire logic [15:0] want_addr,
    input wire logic want_app,
    output logic [15:0] fetch_addr,
    output logic fetch_from_app
);
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fetch_addr <= 16'h0;
            fetch_from_app <= 1'h0;
        end else if (!cpu_stall && !(rww_busy && want_addr < HALT_BASE)) begin
            fetch_addr <= want_addr;
            fetch_from_app <= want_app;
        end
    end
endmodule : cpu_core_model
`default_nettype wire

// file: test/boot_flash_self_program_control_test.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module boot_flash_self_program_control_test;
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, want_app, rww_busy, er, e;
    logic cpu_stall, boot_read_block, app_read_block, flash_op_start, flash_op_erase, fetch_from_app;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] want_addr, fetch_addr, flash_op_addr, t;
    logic [1:0] lk;
    int seed, starts, n0, checks, failures;
    boot_flash_ctrl #(.PROG_CYCLES(5)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fetch_addr(fetch_addr), .fetch_from_app(fetch_from_app), .cpu_stall(cpu_stall),
        .boot_read_block(boot_read_block), .app_read_block(app_read_block), .flash_op_start(flash_op_start),
        .flash_op_erase(flash_op_erase), .flash_op_addr(flash_op_addr));
    cpu_core_model u_core (.core_clk(core_clk), .rst_n(rst_n), .cpu_stall(cpu_stall), .rww_busy(rww_busy),
        .want_addr(want_addr), .want_app(want_app), .fetch_addr(fetch_addr), .fetch_from_app(fetch_from_app));
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (flash_op_start === 1'h1) starts++;
    function automatic logic [15:0] bbase(input logic [1:0] k);
        return k == 2'h0 ? 16'he000 : k == 2'h1 ? 16'hf000 : k == 2'h2 ? 16'hf800 : 16'hfc00;
    endfunction : bbase
    function automatic logic ok(input logic [1:0] k);
        return k[0];
    endfunction : ok
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic cmd(input logic [31:0] d);
        n0 = starts;
        apb(1'h1, boot_flash_pkg::ADDR_CMD, d);
        repeat (2) @(posedge core_clk);
    endtask : cmd
    task automatic idle();
        do begin
            apb(1'h0, boot_flash_pkg::ADDR_STAT, 32'h0);
        end while (rd[2] !== 1'h0);
    endtask : idle
    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    initial begin
        #200000;
        failures++;
        finish_test();
    end
    initial begin
        seed = 34;
        {core_clk, rst_n, psel, penable, pwrite, paddr, pwdata, want_addr, want_app, rww_busy} = '0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'h1;
        apb(1'h0, boot_flash_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'hf);
        apb(1'h0, 8'h10, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        cmd(32'h00100);
        chk(starts - n0, 0);
        idle();
        chk(rd[3:0], 4'h8);
        for (int i = 0; i < 4; i++) begin
            lk = i[1:0];
            apb(1'h1, boot_flash_pkg::ADDR_CTRL, {28'h0, ~lk, lk});
            want_app <= 1'h0;
            want_addr <= 16'h0100;
            repeat (3) @(posedge core_clk);
            chk(app_read_block, !lk[1]);
            want_app <= 1'h1;
            want_addr <= 16'hff00;
            repeat (3) @(posedge core_clk);
            chk(boot_read_block, lk[1]);
            cmd(32'h20100);
            chk(starts - n0, ok(lk));
            chk(cpu_stall, 1'h0);
            rww_busy <= ok(lk);
            idle();
            chk(rd[3:0], {~ok(lk), 2'h0, ok(lk)});
            cmd(32'h2ff00);
            chk(cpu_stall, ok(~lk));
            idle();
            cmd(32'h60000);
            rww_busy <= 1'h0;
            apb(1'h0, boot_flash_pkg::ADDR_STAT, 32'h0);
            chk(rd[0], 0);
        end
        apb(1'h1, boot_flash_pkg::ADDR_CTRL, 32'h3);
        for (int k = 0; k < 4; k++) begin
            apb(1'h1, boot_flash_pkg::ADDR_FUSE, k);
            cmd(32'h20000 | (bbase(k[1:0]) - 16'h100));
            chk(starts - n0, 1);
            idle();
            cmd(32'h20000 | bbase(k[1:0]));
            chk(starts - n0, 0);
        end
        apb(1'h1, boot_flash_pkg::ADDR_CTRL, 32'hf);
        cmd(32'h60000);
        for (int j = 0; j < 16; j++) begin
            t = 16'($random(seed));
            e = 1'($random(seed));
            want_addr <= 16'($random(seed));
            want_app <= 1'($random(seed));
            rww_busy <= rww_busy | (t < 16'he000);
            cmd({14'h0, 1'h1, e, t});
            chk({flash_op_erase, flash_op_addr}, {e, t[15:8], 8'h00});
            chk(cpu_stall, t >= 16'he000);
            idle();
            chk(rd[0], rww_busy);
        end
        rst_n <= 1'h0;
        rww_busy <= 1'h0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'h1;
        apb(1'h0, boot_flash_pkg::ADDR_STAT, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, boot_flash_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'hf);
        finish_test();
    end
endmodule : boot_flash_self_program_control_test
`default_nettype wire
